// file: pkg/err_pkg.sv
// Shared constants and types of the bridge error reporting block
package err_pkg;

	// ************************************************************
	// Register map (byte addresses, one word each)
	// ************************************************************
	localparam logic [7:0] CTRL_OFS  = 8'h00;
	localparam logic [7:0] SDIS_OFS  = 8'h04;
	localparam logic [7:0] PSTAT_OFS = 8'h08;
	localparam logic [7:0] SSTAT_OFS = 8'h0C;
	localparam logic [7:0] ATT_OFS   = 8'h10;

	// Control bits
	localparam int CTL_PRI_RSP = 0;
	localparam int CTL_SERR_EN = 1;
	localparam int CTL_SEC_RSP = 2;
	localparam int CTL_FWD_EN  = 3;

	// System error disable bits, one per posted write cause
	localparam int DIS_PAR  = 0;
	localparam int DIS_RTRY = 1;
	localparam int DIS_TABT = 2;
	localparam int DIS_MABT = 3;

	// Status bits; SSE is signaled (primary) or detected (secondary)
	localparam int ST_DPE = 0;
	localparam int ST_DPR = 1;
	localparam int ST_SSE = 2;
	localparam int ST_RTA = 3;
	localparam int ST_RMA = 4;

	// Values after reset
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [3:0] DIS_RST  = 4'h0;
	localparam logic [4:0] STAT_RST = 5'h00;
	localparam logic [1:0] AGE_RST  = 2'h0;

	// Cycle counts and attempt counter width
	localparam logic [1:0]  PERR_DLY  = 2'h2;
	localparam int          ATT_W     = 25;
	localparam logic [31:0] ATT_LIMIT = 32'h0100_0000;

	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_s;

	typedef struct packed {
		logic        downstream;
		logic        init_wr_perr;
		logic        tgt_rd_perr;
		logic        tgt_wr_perr;
		logic        posted;
		logic        np_wr_xfer;
		logic        pw_enter;
		logic        pw_retry;
		logic        pw_done;
		logic        pw_tabort;
		logic        pw_mabort;
		logic [31:0] wr_ad;
		logic [3:0]  wr_cbe;
		logic        wr_bad;
		logic [31:0] rd_ad;
		logic [3:0]  rd_cbe;
		logic        rd_bad;
	} err_ev_s;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} sync_s;

	localparam sync_s SYNC_RST = '{s1: 1'b1, s2: 1'b1, s3: 1'b1, lvl: 1'b1};

	typedef struct packed {
		logic [ATT_W-1:0] cnt;
		logic             live;
		logic             hit;
	} att_s;

	typedef struct packed {
		logic [3:0]  ctrl;
		logic [3:0]  dis;
		logic [4:0]  pst;
		logic [4:0]  sst;
		logic [1:0]  age;
		logic        pend;
		logic        p_perr;
		logic        s_perr;
		logic        serr;
		logic        ack;
		logic [31:0] dat;
		logic        wpar;
		logic        rpar;
	} top_s;

	// Even parity over address/data and byte enables, inverted when bad
	function automatic logic par_gen(input logic [31:0] ad, input logic [3:0] cbe,
		input logic bad);
		return (^{ad, cbe}) ^ bad;
	endfunction

endpackage

// file: logic/pin_sync.sv
// Three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module pin_sync (
	input  logic clk_i,
	input  logic rst_i,
	input  logic pin_i,
	output logic lvl_o
);
	import err_pkg::*;

	sync_s q;
	sync_s d;

	// ************************************************************
	// Next state
	// ************************************************************
	// Stage one feeds stage two only; level moves when two and three agree
	always_comb begin
		d     = q;
		d.s1  = pin_i;
		d.s2  = q.s1;
		d.s3  = q.s2;
		if (q.s2 == q.s3) begin
			d.lvl = q.s3;
		end
	end

	// Pin idles high, so reset to all ones
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= SYNC_RST;
		end else begin
			q <= d;
		end
	end

	assign lvl_o = q.lvl;
endmodule // pin_sync

// file: logic/att_count.sv
// Delivery attempt counter for the posted write in flight
`timescale 1ns/1ps
module att_count #(
	parameter logic [31:0] LIMIT = err_pkg::ATT_LIMIT
) (
	input  logic                      clk_i,
	input  logic                      rst_i,
	input  logic                      start_i,
	input  logic                      step_i,
	input  logic                      done_i,
	output logic [err_pkg::ATT_W-1:0] count_o,
	output logic                      hit_o
);
	import err_pkg::*;

	localparam logic [ATT_W-1:0] LIM = LIMIT[ATT_W-1:0];

	att_s q;
	att_s d;
	logic [ATT_W-1:0] nxt;

	assign nxt = q.cnt + {{(ATT_W-1){1'b0}}, 1'b1};

	// ************************************************************
	// Counting
	// ************************************************************
	// Stops at the limit so the exhaustion pulse fires only once
	always_comb begin
		d     = q;
		d.hit = 1'b0;
		if (start_i) begin
			d.cnt  = '0; // R19
			d.live = 1'b1;
		end else if (done_i) begin
			d.cnt  = '0; // R19
			d.live = 1'b0;
		end else if (step_i && q.live && q.cnt != LIM) begin
			d.cnt = nxt; // R19
			d.hit = (nxt == LIM); // R11
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign count_o = q.cnt;
	assign hit_o   = q.hit;
endmodule // att_count

// file: logic/err_report.sv
// Data parity and system error reporting of a PCI-to-PCI bridge
//
// Overview of operation
// R1 - Initiating write parity error sets detected flag
// R2 - Initiating perr only with that bus response enable
// R3 - Forwarded write carries the same bad parity
// R4 - Target read error: flag, perr if enabled
// R5 - Read error sets data-reported when response enabled
// R6 - Read data returned with its bad parity
// R7 - Target perr on write sets data-reported
// R8 - Non-posted: initiating perr two cycles after transfer
// R9 - Late non-posted error raises primary system error
// R10 - Posted write target perr raises system error
// R11 - Retry exhaustion after 2^24 attempts raises error
// R12 - Posted target abort: error, received-target-abort flag
// R13 - Posted master abort: error, received-master-abort flag
// R14 - Each posted cause has own disable bit
// R15 - Forward secondary system error when enabled
// R16 - Secondary system error pin is input only
// R17 - Driver enable gates; each drive sets signaled
// R18 - Retry exhaustion sets only signaled system error
// R19 - Attempt counter zeroed on entry, steps, clears
//
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/1ps
module err_report #(
	parameter logic [31:0] ATT_LIMIT = err_pkg::ATT_LIMIT
) (
	input  logic             clk_i,
	input  logic             rst_i,
	input  err_pkg::wb_req_s wb_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  err_pkg::err_ev_s ev_i,
	input  logic             s_serr_n_i,
	output logic             p_serr_n_o,
	output logic             p_serr_oe_o,
	output logic             p_perr_n_o,
	output logic             p_perr_oe_o,
	output logic             s_perr_n_o,
	output logic             s_perr_oe_o,
	output logic             wpar_o,
	output logic             rpar_o
);
	import err_pkg::*;

	top_s q;
	top_s d;

	logic             sserr_n;
	logic [ATT_W-1:0] att_cnt;
	logic             att_hit;
	logic             init_rsp;
	logic             tgt_rsp;
	logic             np_timely;
	logic             np_late;
	logic             np_fire;
	logic             fwd_hit;
	logic             serr_fire;
	logic             wr_good;
	logic             rd_good;
	logic [4:0]       init_set;
	logic [4:0]       tgt_set;
	logic [4:0]       pset;
	logic [4:0]       sset;
	logic [4:0]       pclr;
	logic [4:0]       sclr;
	logic             wb_hit;
	logic             wb_wr;

	// ************************************************************
	// Submodules
	// ************************************************************
	// Secondary system error is only ever sampled, never driven
	pin_sync u_sserr (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.pin_i (s_serr_n_i), // R16
		.lvl_o (sserr_n)
	);

	att_count #(
		.LIMIT (ATT_LIMIT)
	) u_att (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.start_i (ev_i.pw_enter),
		.step_i  (ev_i.pw_retry),
		.done_i  (ev_i.pw_done),
		.count_o (att_cnt),
		.hit_o   (att_hit)
	);

	// ************************************************************
	// Bus roles
	// ************************************************************
	// Downstream: primary initiates, secondary is the target bus
	assign init_rsp = ev_i.downstream ? q.ctrl[CTL_PRI_RSP] : q.ctrl[CTL_SEC_RSP];
	assign tgt_rsp  = ev_i.downstream ? q.ctrl[CTL_SEC_RSP] : q.ctrl[CTL_PRI_RSP];

	// Non-posted window: target error must land by the first cycle after
	assign np_timely = ev_i.tgt_wr_perr && !ev_i.posted
		&& (ev_i.np_wr_xfer || q.age == 2'h1);
	assign np_late   = ev_i.tgt_wr_perr && !ev_i.posted && !np_timely; // R9
	assign np_fire   = (q.age == PERR_DLY - 2'h1)
		&& (q.pend || (np_timely && init_rsp)); // R8

	// ************************************************************
	// System error causes
	// ************************************************************
	// Any cause reaches the pin only through the driver enable
	assign fwd_hit   = !sserr_n && q.ctrl[CTL_FWD_EN]; // R15
	assign serr_fire = q.ctrl[CTL_SERR_EN] && ( // R17
		(tgt_rsp && !q.dis[DIS_PAR] && ev_i.tgt_wr_perr
			&& (ev_i.posted || np_late)) // R10
		|| (att_hit && !q.dis[DIS_RTRY]) // R11
		|| (ev_i.pw_tabort && !q.dis[DIS_TABT]) // R12
		|| (ev_i.pw_mabort && !q.dis[DIS_MABT]) // R13
		|| fwd_hit); // R15

	// ************************************************************
	// Status set terms
	// ************************************************************
	// Retry exhaustion adds no flag beyond signaled system error
	always_comb begin
		init_set         = 5'h00;
		tgt_set          = 5'h00;
		init_set[ST_DPE] = ev_i.init_wr_perr; // R1
		tgt_set[ST_DPE]  = ev_i.tgt_rd_perr; // R4
		tgt_set[ST_DPR]  = tgt_rsp && (ev_i.tgt_rd_perr || ev_i.tgt_wr_perr); // R5 R7
		tgt_set[ST_RTA]  = ev_i.pw_tabort; // R12
		tgt_set[ST_RMA]  = ev_i.pw_mabort; // R13
		pset             = ev_i.downstream ? init_set : tgt_set;
		sset             = ev_i.downstream ? tgt_set : init_set;
		pset[ST_SSE]     = serr_fire; // R18
		sset[ST_SSE]     = fwd_hit; // R15
	end

	// ************************************************************
	// Register bus
	// ************************************************************
	// Write lands on the edge the master samples ack
	assign wb_hit = wb_i.cyc && wb_i.stb;
	assign wb_wr  = wb_hit && wb_i.we && q.ack && wb_i.sel[0];
	assign pclr   = (wb_wr && wb_i.adr == PSTAT_OFS) ? wb_i.dat[4:0] : 5'h00;
	assign sclr   = (wb_wr && wb_i.adr == SSTAT_OFS) ? wb_i.dat[4:0] : 5'h00;

	assign wr_good = par_gen(ev_i.wr_ad, ev_i.wr_cbe, 1'b0);
	assign rd_good = par_gen(ev_i.rd_ad, ev_i.rd_cbe, 1'b0);

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		d     = q;
		d.ack = wb_hit && !q.ack;
		d.dat = 32'h0000_0000;
		if (d.ack && !wb_i.we) begin
			case (wb_i.adr)
				CTRL_OFS:  d.dat = {28'h000_0000, q.ctrl};
				SDIS_OFS:  d.dat = {28'h000_0000, q.dis};
				PSTAT_OFS: d.dat = {27'h000_0000, q.pst};
				SSTAT_OFS: d.dat = {27'h000_0000, q.sst};
				ATT_OFS:   d.dat = {{(32-ATT_W){1'b0}}, att_cnt};
				default:   d.dat = 32'h0000_0000;
			endcase
		end
		if (wb_wr && wb_i.adr == CTRL_OFS) begin
			d.ctrl = wb_i.dat[3:0];
		end
		if (wb_wr && wb_i.adr == SDIS_OFS) begin
			d.dis = wb_i.dat[3:0]; // R14
		end
		// Set beats clear so no event slips past software
		d.pst = (q.pst & ~pclr) | pset;
		d.sst = (q.sst & ~sclr) | sset;

		// Non-posted window age, idle at zero
		if (ev_i.np_wr_xfer) begin
			d.age = 2'h1;
		end else if (q.age == PERR_DLY - 2'h1) begin
			d.age = AGE_RST;
		end else begin
			d.age = q.age;
		end
		d.pend = (q.age == PERR_DLY - 2'h1) ? 1'b0
			: (q.pend || (np_timely && init_rsp));

		// Parity error pins, one cycle per event
		d.p_perr = ev_i.downstream
			? ((ev_i.init_wr_perr && init_rsp) || np_fire) // R2
			: (ev_i.tgt_rd_perr && tgt_rsp); // R4
		d.s_perr = ev_i.downstream
			? (ev_i.tgt_rd_perr && tgt_rsp) // R4
			: ((ev_i.init_wr_perr && init_rsp) || np_fire); // R8
		d.serr   = serr_fire; // R17

		// Parity travels one cycle behind its data, bad stays bad
		d.wpar = par_gen(ev_i.wr_ad, ev_i.wr_cbe, ev_i.wr_bad); // R3
		d.rpar = par_gen(ev_i.rd_ad, ev_i.rd_cbe, ev_i.rd_bad); // R6
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q      <= '0;
			q.ctrl <= CTRL_RST;
			q.dis  <= DIS_RST;
			q.pst  <= STAT_RST;
			q.sst  <= STAT_RST;
			q.age  <= AGE_RST;
		end else begin
			q <= d;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	// Open-drain pins pull low only while enabled
	assign wb_dat_o    = q.dat;
	assign wb_ack_o    = q.ack;
	assign p_serr_n_o  = 1'b0;
	assign p_serr_oe_o = q.serr;
	assign p_perr_n_o  = 1'b0;
	assign p_perr_oe_o = q.p_perr;
	assign s_perr_n_o  = 1'b0;
	assign s_perr_oe_o = q.s_perr;
	assign wpar_o      = q.wpar;
	assign rpar_o      = q.rpar;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	init_dpe_flag_a: assert property ( // R1
		ev_i.init_wr_perr && ev_i.downstream |=> q.pst[ST_DPE])
		else $error("initiating parity flag not set");

	init_perr_pin_a: assert property ( // R2
		ev_i.init_wr_perr && ev_i.downstream && q.ctrl[CTL_PRI_RSP]
		|=> p_perr_oe_o)
		else $error("initiating perr not driven");

	wr_parity_fwd_a: assert property ( // R3
		ev_i.wr_bad |=> wpar_o == !$past(wr_good))
		else $error("bad write parity not forwarded");

	rd_perr_flags_a: assert property ( // R5
		ev_i.tgt_rd_perr && ev_i.downstream && q.ctrl[CTL_SEC_RSP]
		|=> s_perr_oe_o && q.sst[ST_DPR] && q.sst[ST_DPE])
		else $error("target read parity error not reported");

	rd_parity_ret_a: assert property ( // R6
		ev_i.rd_bad |=> rpar_o == !$past(rd_good))
		else $error("bad read parity not returned");

	np_perr_delay_a: assert property ( // R8
		ev_i.np_wr_xfer && np_timely && ev_i.downstream && q.ctrl[CTL_PRI_RSP]
		|-> !p_perr_oe_o[*1] ##1 !p_perr_oe_o ##1 p_perr_oe_o)
		else $error("non-posted perr not two cycles after transfer");

	pw_par_serr_a: assert property ( // R10
		ev_i.tgt_wr_perr && ev_i.posted && ev_i.downstream
		&& q.ctrl[CTL_SEC_RSP] && q.ctrl[CTL_SERR_EN] && !q.dis[DIS_PAR]
		|=> p_serr_oe_o ##0 q.pst[ST_SSE])
		else $error("posted parity error did not raise serr");

	retry_serr_a: assert property ( // R11
		att_hit && q.ctrl[CTL_SERR_EN] && !q.dis[DIS_RTRY] |=> p_serr_oe_o)
		else $error("retry exhaustion did not raise serr");

	tabort_flag_a: assert property ( // R12
		ev_i.pw_tabort && ev_i.downstream |=> q.sst[ST_RTA])
		else $error("received target abort not flagged");

	all_disabled_a: assert property ( // R14
		q.dis == 4'hF && !q.ctrl[CTL_FWD_EN] |=> !p_serr_oe_o)
		else $error("disabled cause drove serr");

	sserr_fwd_a: assert property ( // R15
		!sserr_n && q.ctrl[CTL_FWD_EN] && q.ctrl[CTL_SERR_EN]
		|=> p_serr_oe_o && q.sst[ST_SSE] && q.pst[ST_SSE])
		else $error("secondary serr not forwarded");

	serr_gate_a: assert property ( // R17
		!q.ctrl[CTL_SERR_EN] |=> !p_serr_oe_o)
		else $error("serr driven without driver enable");

	serr_signal_a: assert property ( // R17
		p_serr_oe_o |-> q.pst[ST_SSE])
		else $error("serr driven without signaled flag");

	wb_ack_pulse_a: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held more than one cycle");

	cov_np_perr_c: cover property (ev_i.np_wr_xfer ##2 p_perr_oe_o);
	cov_pw_serr_c: cover property (ev_i.tgt_wr_perr && ev_i.posted ##1 p_serr_oe_o);
	cov_fwd_c:     cover property (fwd_hit ##1 p_serr_oe_o);
	cov_retry_c:   cover property (att_hit ##1 p_serr_oe_o);
endmodule // err_report

// file: tb/bus_side.sv
// Behavioural model of the bridge datapath events and the secondary bus error pin
`timescale 1ns/1ps
module bus_side (
	input  wire logic    clk_i,
	output err_pkg::err_ev_s ev_o,
	output logic         s_serr_n_o
);
	import err_pkg::*;

	// Idle at start: no events, primary initiates, secondary pin pulled high
	initial begin
		ev_o = '0;
		ev_o.downstream = 1'b1;
		s_serr_n_o = 1'b1;
	end

	// One-cycle event pulses; bit 0 init write, 1 read, 2 target write, 3 np xfer,
	// 4 enter, 5 retry, 6 done, 7 target abort, 8 master abort
	task automatic fire(input logic [8:0] m, input logic pst);
		@(posedge clk_i);
		{ev_o.pw_mabort, ev_o.pw_tabort, ev_o.pw_done, ev_o.pw_retry, ev_o.pw_enter,
			ev_o.np_wr_xfer, ev_o.tgt_wr_perr, ev_o.tgt_rd_perr, ev_o.init_wr_perr} <= m;
		ev_o.posted <= pst;
		@(posedge clk_i);
		{ev_o.pw_mabort, ev_o.pw_tabort, ev_o.pw_done, ev_o.pw_retry, ev_o.pw_enter,
			ev_o.np_wr_xfer, ev_o.tgt_wr_perr, ev_o.tgt_rd_perr, ev_o.init_wr_perr} <= 9'h000;
	endtask

	// Same word on both data paths, so one parity figure serves both
	task automatic data(input logic [31:0] ad, input logic [3:0] cbe, input logic bad);
		@(posedge clk_i);
		{ev_o.wr_ad, ev_o.wr_cbe, ev_o.wr_bad} <= {ad, cbe, bad};
		{ev_o.rd_ad, ev_o.rd_cbe, ev_o.rd_bad} <= {ad, cbe, bad};
	endtask

	// Transfer direction, 1 while the primary side initiates
	task automatic set_dir(input logic v);
		@(posedge clk_i);
		ev_o.downstream <= v;
	endtask

	// Secondary system error pin, low while a device reports
	task automatic serr(input logic v);
		@(posedge clk_i);
		s_serr_n_o <= v;
	endtask
endmodule // bus_side

// file: tb/test_err_report.sv
// Self-checking bench of the bridge error reporting block
`timescale 1ns/1ps
module test_err_report;
	import err_pkg::*;

	// ************************************************************
	// Signals and bookkeeping
	// ************************************************************
	localparam logic [31:0] PR  = 32'h1 << CTL_PRI_RSP;
	localparam logic [31:0] SE  = 32'h1 << CTL_SERR_EN;
	localparam logic [31:0] SR  = 32'h1 << CTL_SEC_RSP;
	localparam logic [31:0] FW  = 32'h1 << CTL_FWD_EN;
	localparam logic [31:0] SSE = 32'h1 << ST_SSE;
	localparam logic [31:0] LIM = 32'h0000_0004;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	wb_req_s     wb = '0;
	err_ev_s     ev;
	logic        s_serr_n;
	logic        p_serr_oe;
	logic        p_perr_oe;
	logic        s_perr_oe;
	logic        wpar;
	logic        rpar;
	logic [2:0]  pin_n;
	logic        wb_ack;
	logic [31:0] wb_dat;
	logic [31:0] rd;
	int          n_errors = 0;
	int          checks = 0;
	int          cyc_cnt = 0;

	// Small attempt limit keeps the retry test short
	err_report #(.ATT_LIMIT(LIM)) i_err_report (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb),
		.wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .ev_i(ev), .s_serr_n_i(s_serr_n),
		.p_serr_n_o(pin_n[2]), .p_serr_oe_o(p_serr_oe), .p_perr_n_o(pin_n[1]),
		.p_perr_oe_o(p_perr_oe), .s_perr_n_o(pin_n[0]), .s_perr_oe_o(s_perr_oe),
		.wpar_o(wpar), .rpar_o(rpar));
	bus_side i_bus_side (.clk_i(clk_i), .ev_o(ev), .s_serr_n_o(s_serr_n));

	// 40 MHz clock
	always #12.5 clk_i = ~clk_i;

	// Hang guard, far above the few hundred cycles the tests need
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 3000) begin
			n_errors++;
			give_verdict();
		end
	end

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic give_verdict;
		$display("Counts: %0d checks, %0d mismatches", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// Classic cycle: hold until ack is sampled, take data at that edge, then release
	task automatic wb_go(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
		do @(posedge clk_i); while (wb_ack !== 1'b1);
		rd = wb_dat;
		wb <= '0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		wb_go(1'b0, a, 32'h0);
		chk(rd, e);
	endtask

	// Status is sticky, so every test starts from clean flags
	task automatic setup(input logic [31:0] ctl, input logic [31:0] dis);
		wb_go(1'b1, CTRL_OFS, ctl);
		wb_go(1'b1, SDIS_OFS, dis);
		wb_go(1'b1, PSTAT_OFS, 32'h1F);
		wb_go(1'b1, SSTAT_OFS, 32'h1F);
	endtask

	task automatic nxt;
		@(posedge clk_i);
		#1;
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_regs;
		rdc(CTRL_OFS, 32'(CTRL_RST));
		rdc(SDIS_OFS, 32'(DIS_RST));
		rdc(PSTAT_OFS, 32'(STAT_RST));
		rdc(SSTAT_OFS, 32'(STAT_RST));
		rdc(ATT_OFS, 32'h0);
		wb_go(1'b1, 8'h14, 32'hFFFF_FFFF);
		rdc(8'h14, 32'h0);
		wb_go(1'b1, CTRL_OFS, 32'hFFFF_FFFF);
		rdc(CTRL_OFS, 32'h0000_000F);
		chk(32'(pin_n), 32'h0);
		$display("test registers done");
	endtask

	task automatic t_init;
		setup(32'h0, 32'h0);
		i_bus_side.data(32'hA5C3_0F1E, 4'h6, 1'b1);
		i_bus_side.fire(9'h001, 1'b0);
		#1 chk(p_perr_oe, 1'b0);
		chk(wpar, (^{32'hA5C3_0F1E, 4'h6}) ^ 1'b1);
		chk(rpar, (^{32'hA5C3_0F1E, 4'h6}) ^ 1'b1);
		rdc(PSTAT_OFS, 32'h1 << ST_DPE);
		wb_go(1'b1, CTRL_OFS, PR);
		i_bus_side.fire(9'h001, 1'b0);
		#1 chk(p_perr_oe, 1'b1);
		nxt();
		chk(p_perr_oe, 1'b0);
		i_bus_side.data(32'h0000_0001, 4'h0, 1'b0);
		nxt();
		chk(wpar, 1'b1);
		$display("test initiating write done");
	endtask

	task automatic t_read;
		setup(32'h0, 32'h0);
		i_bus_side.fire(9'h002, 1'b0);
		#1 chk(s_perr_oe, 1'b0);
		rdc(SSTAT_OFS, 32'h1 << ST_DPE);
		setup(SR, 32'h0);
		i_bus_side.fire(9'h002, 1'b0);
		#1 chk(s_perr_oe, 1'b1);
		rdc(SSTAT_OFS, (32'h1 << ST_DPE) | (32'h1 << ST_DPR));
		$display("test target read done");
	endtask

	task automatic t_nonposted;
		setup(PR | SR | SE, 32'h0);
		i_bus_side.fire(9'h00C, 1'b0);
		#1 chk(p_perr_oe, 1'b0);
		nxt();
		chk(p_perr_oe, 1'b1);
		chk(p_serr_oe, 1'b0);
		rdc(SSTAT_OFS, 32'h1 << ST_DPR);
		setup(PR | SR | SE, 32'h0);
		i_bus_side.fire(9'h008, 1'b0);
		i_bus_side.fire(9'h004, 1'b0);
		#1 chk(p_serr_oe, 1'b1);
		chk(p_perr_oe, 1'b0);
		rdc(PSTAT_OFS, SSE);
		$display("test non-posted write done");
	endtask

	task automatic t_posted;
		setup(SR | SE, 32'h1 << DIS_PAR);
		i_bus_side.fire(9'h004, 1'b1);
		#1 chk(p_serr_oe, 1'b0);
		setup(SR, 32'h0);
		i_bus_side.fire(9'h004, 1'b1);
		#1 chk(p_serr_oe, 1'b0);
		rdc(PSTAT_OFS, 32'h0);
		setup(SR | SE, 32'h0);
		i_bus_side.fire(9'h004, 1'b1);
		#1 chk(p_serr_oe, 1'b1);
		nxt();
		chk(p_serr_oe, 1'b0);
		rdc(PSTAT_OFS, SSE);
		$display("test posted parity done");
	endtask

	task automatic t_retry;
		setup(SE, 32'h0);
		i_bus_side.fire(9'h010, 1'b1);
		repeat (3) i_bus_side.fire(9'h020, 1'b1);
		#1 chk(p_serr_oe, 1'b0);
		rdc(ATT_OFS, LIM - 32'h1);
		i_bus_side.fire(9'h020, 1'b1);
		nxt(); // Exhaustion pulse is registered once more before the pin
		chk(p_serr_oe, 1'b1);
		rdc(PSTAT_OFS, SSE);
		rdc(SSTAT_OFS, 32'h0);
		i_bus_side.fire(9'h040, 1'b1);
		rdc(ATT_OFS, 32'h0);
		$display("test retry exhaustion done");
	endtask

	task automatic t_abort;
		for (int i = 0; i < 2; i++) begin
			for (int d = 0; d < 2; d++) begin
				setup(SE, d ? (32'h1 << (DIS_TABT + i)) : 32'h0);
				i_bus_side.fire(9'h080 << i, 1'b1);
				#1 chk(p_serr_oe, d ? 1'b0 : 1'b1);
				rdc(SSTAT_OFS, 32'h1 << (ST_RTA + i));
			end
		end
		$display("test aborts done");
	endtask

	task automatic t_fwd;
		setup(SE, 32'h0);
		i_bus_side.serr(1'b0);
		repeat (6) nxt();
		chk(p_serr_oe, 1'b0);
		i_bus_side.serr(1'b1);
		setup(SE | FW, 32'h0);
		i_bus_side.serr(1'b0);
		repeat (6) nxt();
		chk(p_serr_oe, 1'b1);
		rdc(PSTAT_OFS, SSE);
		rdc(SSTAT_OFS, SSE);
		i_bus_side.serr(1'b1);
		repeat (6) nxt();
		chk(p_serr_oe, 1'b0);
		$display("test forwarding done");
	endtask

	// Reverse direction: secondary initiates, primary is the target bus
	task automatic t_up;
		i_bus_side.set_dir(1'b0);
		setup(SR, 32'h0);
		i_bus_side.fire(9'h001, 1'b0);
		#1 chk(s_perr_oe, 1'b1);
		rdc(SSTAT_OFS, 32'h1 << ST_DPE);
		setup(PR, 32'h0);
		i_bus_side.fire(9'h002, 1'b0);
		#1 chk(p_perr_oe, 1'b1);
		rdc(PSTAT_OFS, (32'h1 << ST_DPE) | (32'h1 << ST_DPR));
		i_bus_side.set_dir(1'b1);
		$display("test upstream done");
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_init();
		t_read();
		t_nonposted();
		t_posted();
		t_retry();
		t_abort();
		t_fwd();
		t_up();
		give_verdict();
	end
endmodule // test_err_report
